//--- mbrbs_pkg.sv
// Operation
// - A bit read is answered with ID, function code, byte count, the packed bit bytes and the CRC.
// - The byte count of a bit read is the bit count divided by 8, rounded up.
// - Function 0x02 reads bits with the same request and reply layouts as function 0x01.
// - A single-bit value of 0x0000 clears the bit and 0xFF00 sets it.
// - A good single-bit write is answered by echoing ID, function, address and value with a fresh CRC.
// - Output bit 0 sits at bit address 0xA000 and later bits follow on, so byte 2 bit 0 is 0xA010.
// - Memory words zero and one sit at word addresses 0x0000 and 0x0001, written upward by function 0x10.
// - Two-byte fields go high byte first, while the CRC goes low byte first.
// - A good multi-word write is answered with ID, function, start address, word count and the CRC.
package mbrbs_pkg;
	// ==========================================================
	// Function and exception codes
	localparam logic [7:0] FC_READ_OUT = 8'h01;
	localparam logic [7:0] FC_READ_BITS = 8'h02;
	localparam logic [7:0] FC_WRITE_BIT = 8'h05;
	localparam logic [7:0] FC_WRITE_WORDS = 8'h10;
	localparam logic [7:0] EXC_FLAG = 8'h80;
	localparam logic [7:0] EXC_FUNC = 8'h01;
	localparam logic [7:0] EXC_ADDR = 8'h02;
	localparam logic [7:0] EXC_DATA = 8'h03;
	// ==========================================================
	// Address map and field values
	localparam logic [15:0] BIT_BASE = 16'hA000;
	localparam int OUT_BITS = 1024;
	localparam logic [16:0] OUT_BITS_17 = 17'h00400;
	localparam logic [15:0] MAX_READ_BITS = 16'h0100;
	localparam int MEM_WORDS = 16;
	localparam logic [16:0] MEM_WORDS_17 = 17'h00010;
	localparam logic [15:0] VAL_FALSE = 16'h0000;
	localparam logic [15:0] VAL_TRUE = 16'hFF00;
	// ==========================================================
	// Frame layout
	localparam int RX_MAX = 48;
	localparam int IDX_W = 6;
	localparam logic [5:0] MIN_FRAME = 6'h04;
	localparam logic [5:0] FIXED_LEN = 6'h08;
	localparam logic [5:0] WORDS_EXTRA = 6'h09;
	localparam int WORDS_DATA = 7;
	localparam logic [5:0] EXC_BODY = 6'h03;
	localparam logic [5:0] READ_HDR = 6'h03;
	localparam logic [5:0] ECHO_BODY = 6'h06;
	localparam logic [15:0] CRC_INIT = 16'hFFFF;
	localparam logic [15:0] CRC_POLY = 16'hA001;

	typedef enum logic [1:0]
	{
		ST_IDLE = 2'b00,
		ST_CHECK = 2'b01,
		ST_SEND = 2'b11
	} mbrbs_state_e;

	typedef struct packed
	{
		logic valid;
		logic [7:0] data;
	} mbrbs_rx_s;

	typedef struct packed
	{
		logic valid;
		logic last;
		logic [7:0] data;
	} mbrbs_tx_s;

	// One byte of the reflected Modbus CRC-16
	function automatic logic [15:0] crc_byte(logic [15:0] c, logic [7:0] d);
		logic [15:0] r;
		r = c ^ {8'h00, d};
		for (int i = 0; i < 8; i++)
		begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction

	function automatic logic is_read(logic [7:0] fc);
		return (fc == FC_READ_OUT) || (fc == FC_READ_BITS);
	endfunction
endpackage

//--- mbrbs_slave.sv
`timescale 1ns/1ps
module mbrbs_slave
(
	// Clock and reset
	input wire logic clk,
	input wire logic resetn,
	// Configuration
	input wire logic [7:0] slave_id,
	// Received bytes from the serial layer
	input wire mbrbs_pkg::mbrbs_rx_s rx,
	input wire logic rx_frame_end,
	// Reply bytes to the serial layer
	output mbrbs_pkg::mbrbs_tx_s tx,
	input wire logic tx_ready,
	// Storage areas
	output logic [mbrbs_pkg::OUT_BITS-1:0] output_bit_area,
	output logic [mbrbs_pkg::MEM_WORDS-1:0][15:0] memory_word_area
);
	// ==========================================================
	// State
	mbrbs_pkg::mbrbs_state_e state_reg, state_next;
	logic [7:0] buf_reg [mbrbs_pkg::RX_MAX];
	logic [7:0] buf_next [mbrbs_pkg::RX_MAX];
	logic [5:0] cnt_reg, cnt_next;
	logic ovf_reg, ovf_next;
	logic [15:0] crc_rx_reg, crc_rx_next, crc_tx_reg, crc_tx_next;
	logic [mbrbs_pkg::OUT_BITS-1:0] bits_reg, bits_next;
	logic [mbrbs_pkg::MEM_WORDS-1:0][15:0] mem_reg, mem_next;
	logic tx_valid_reg, tx_valid_next, tx_last_reg, tx_last_next;
	logic [7:0] tx_data_reg, tx_data_next;
	logic [5:0] idx_reg, idx_next, body_len_reg, body_len_next;
	logic exc_reg, exc_next;
	logic [7:0] code_reg, code_next, fc_reg, fc_next, bc_reg, bc_next;
	logic [15:0] qty_reg, qty_next;
	logic [9:0] start_reg, start_next;

	// Request fields, valid while in ST_CHECK
	logic [7:0] req_fc;
	logic [15:0] req_addr, req_qty, boff, first_word;
	logic [16:0] bit_end, word_end;
	logic [5:0] nidx;
	logic [7:0] nbyte, packed_byte;
	logic [10:0] bpos;

	assign req_fc = buf_reg[1];
	assign req_addr = {buf_reg[2], buf_reg[3]};
	assign req_qty = {buf_reg[4], buf_reg[5]};
	assign boff = req_addr - mbrbs_pkg::BIT_BASE;
	assign bit_end = {1'b0, boff} + {1'b0, req_qty};
	assign word_end = {1'b0, req_addr} + {1'b0, req_qty};
	assign first_word = {buf_reg[mbrbs_pkg::WORDS_DATA],
		buf_reg[mbrbs_pkg::WORDS_DATA+1]};

	// ==========================================================
	// Next reply byte
	always_comb
	begin
		nidx = idx_reg + 6'h01;
		packed_byte = 8'h00;
		for (int j = 0; j < 8; j++)
		begin
			bpos = 11'({nidx - mbrbs_pkg::READ_HDR, 3'(j)});
			// First bit lands in bit 0, tail bits read zero
			if ({5'h00, bpos} < qty_reg)
				packed_byte[j] = bits_reg[10'(start_reg + bpos[9:0])];
		end
		if (nidx < body_len_reg)
		begin
			if (nidx == 6'h01)
				nbyte = exc_reg ? (fc_reg | mbrbs_pkg::EXC_FLAG) : fc_reg;
			else if (exc_reg)
				nbyte = code_reg;
			else if (mbrbs_pkg::is_read(fc_reg))
				nbyte = (nidx == 6'h02) ? bc_reg : packed_byte;
			else
				nbyte = buf_reg[nidx];
		end
		else if (nidx == body_len_reg)
			nbyte = crc_tx_reg[7:0];
		else
			nbyte = crc_tx_reg[15:8];
	end

	// ==========================================================
	// Main next-state logic
	always_comb
	begin
		state_next = state_reg;
		buf_next = buf_reg;
		cnt_next = cnt_reg;
		ovf_next = ovf_reg;
		crc_rx_next = crc_rx_reg;
		crc_tx_next = crc_tx_reg;
		bits_next = bits_reg;
		mem_next = mem_reg;
		tx_valid_next = tx_valid_reg;
		tx_last_next = tx_last_reg;
		tx_data_next = tx_data_reg;
		idx_next = idx_reg;
		body_len_next = body_len_reg;
		exc_next = exc_reg;
		code_next = code_reg;
		fc_next = fc_reg;
		bc_next = bc_reg;
		qty_next = qty_reg;
		start_next = start_reg;
		unique case (state_reg)
			mbrbs_pkg::ST_IDLE:
			begin
				// Bytes landing with the frame end are dropped, and the frame is still checked without them
				if (rx_frame_end)
				begin
					cnt_next = 6'h00;
					ovf_next = 1'b0;
					crc_rx_next = mbrbs_pkg::CRC_INIT;
					// Residue of zero means the trailing CRC matched
					if (crc_rx_reg == 16'h0000 && !ovf_reg &&
						cnt_reg >= mbrbs_pkg::MIN_FRAME &&
						buf_reg[0] == slave_id)
					begin
						state_next = mbrbs_pkg::ST_CHECK;
						cnt_next = cnt_reg;
					end
				end
				else if (rx.valid)
				begin
					crc_rx_next = mbrbs_pkg::crc_byte(crc_rx_reg, rx.data);
					if (cnt_reg == 6'(mbrbs_pkg::RX_MAX))
						ovf_next = 1'b1;
					else
					begin
						buf_next[cnt_reg] = rx.data;
						cnt_next = cnt_reg + 6'h01;
					end
				end
			end
			mbrbs_pkg::ST_CHECK:
			begin
				code_next = 8'h00;
				unique case (req_fc)
					mbrbs_pkg::FC_READ_OUT, mbrbs_pkg::FC_READ_BITS:
					begin
						if (cnt_reg != mbrbs_pkg::FIXED_LEN || req_qty == 16'h0000 ||
							req_qty > mbrbs_pkg::MAX_READ_BITS)
							code_next = mbrbs_pkg::EXC_DATA;
						else if (req_addr < mbrbs_pkg::BIT_BASE ||
							bit_end > mbrbs_pkg::OUT_BITS_17)
							code_next = mbrbs_pkg::EXC_ADDR;
					end
					mbrbs_pkg::FC_WRITE_BIT:
					begin
						if (cnt_reg != mbrbs_pkg::FIXED_LEN ||
							(req_qty != mbrbs_pkg::VAL_FALSE &&
							req_qty != mbrbs_pkg::VAL_TRUE))
							code_next = mbrbs_pkg::EXC_DATA;
						else if (req_addr < mbrbs_pkg::BIT_BASE ||
							{1'b0, boff} >= mbrbs_pkg::OUT_BITS_17)
							code_next = mbrbs_pkg::EXC_ADDR;
						else
							bits_next[boff[9:0]] = (req_qty == mbrbs_pkg::VAL_TRUE);
					end
					mbrbs_pkg::FC_WRITE_WORDS:
					begin
						if (req_qty == 16'h0000 ||
							{1'b0, req_qty} > mbrbs_pkg::MEM_WORDS_17 ||
							buf_reg[6] != {req_qty[6:0], 1'b0} ||
							cnt_reg != mbrbs_pkg::WORDS_EXTRA + {req_qty[4:0], 1'b0})
							code_next = mbrbs_pkg::EXC_DATA;
						else if (word_end > mbrbs_pkg::MEM_WORDS_17)
							code_next = mbrbs_pkg::EXC_ADDR;
						else
						begin
							// Words land upward from the start address
							for (int k = 0; k < mbrbs_pkg::MEM_WORDS; k++)
							begin
								if (16'(k) < req_qty)
									mem_next[4'(req_addr[3:0] + 4'(k))] =
										{buf_reg[mbrbs_pkg::WORDS_DATA + 2*k],
										buf_reg[mbrbs_pkg::WORDS_DATA + 2*k + 1]};
							end
						end
					end
					default:
						code_next = mbrbs_pkg::EXC_FUNC;
				endcase
				exc_next = (code_next != 8'h00);
				fc_next = req_fc;
				qty_next = req_qty;
				start_next = boff[9:0];
				bc_next = 8'((req_qty + 16'h0007) >> 3);
				if (exc_next)
					body_len_next = mbrbs_pkg::EXC_BODY;
				else if (mbrbs_pkg::is_read(req_fc))
					body_len_next = mbrbs_pkg::READ_HDR + bc_next[5:0];
				else
					body_len_next = mbrbs_pkg::ECHO_BODY;
				tx_valid_next = 1'b1;
				tx_last_next = 1'b0;
				tx_data_next = buf_reg[0];
				idx_next = 6'h00;
				crc_tx_next = mbrbs_pkg::crc_byte(mbrbs_pkg::CRC_INIT, buf_reg[0]);
				cnt_next = 6'h00;
				state_next = mbrbs_pkg::ST_SEND;
			end
			mbrbs_pkg::ST_SEND:
			begin
				if (tx_ready)
				begin
					if (tx_last_reg)
					begin
						tx_valid_next = 1'b0;
						tx_last_next = 1'b0;
						state_next = mbrbs_pkg::ST_IDLE;
					end
					else
					begin
						idx_next = nidx;
						tx_data_next = nbyte;
						tx_last_next = (nidx == body_len_reg + 6'h01);
						if (nidx < body_len_reg)
							crc_tx_next = mbrbs_pkg::crc_byte(crc_tx_reg, nbyte);
					end
				end
			end
			default:
				state_next = mbrbs_pkg::ST_IDLE;
		endcase
	end

	// ==========================================================
	// Registers
	always_ff @(posedge clk)
	begin
		if (!resetn)
		begin
			state_reg <= mbrbs_pkg::ST_IDLE;
			for (int i = 0; i < mbrbs_pkg::RX_MAX; i++)
				buf_reg[i] <= 8'h00;
			cnt_reg <= 6'h00;
			ovf_reg <= 1'b0;
			crc_rx_reg <= mbrbs_pkg::CRC_INIT;
			crc_tx_reg <= mbrbs_pkg::CRC_INIT;
			bits_reg <= '0;
			mem_reg <= '0;
			tx_valid_reg <= 1'b0;
			tx_last_reg <= 1'b0;
			tx_data_reg <= 8'h00;
			idx_reg <= 6'h00;
			body_len_reg <= 6'h00;
			exc_reg <= 1'b0;
			code_reg <= 8'h00;
			fc_reg <= 8'h00;
			bc_reg <= 8'h00;
			qty_reg <= 16'h0000;
			start_reg <= 10'h000;
		end
		else
		begin
			state_reg <= state_next;
			buf_reg <= buf_next;
			cnt_reg <= cnt_next;
			ovf_reg <= ovf_next;
			crc_rx_reg <= crc_rx_next;
			crc_tx_reg <= crc_tx_next;
			bits_reg <= bits_next;
			mem_reg <= mem_next;
			tx_valid_reg <= tx_valid_next;
			tx_last_reg <= tx_last_next;
			tx_data_reg <= tx_data_next;
			idx_reg <= idx_next;
			body_len_reg <= body_len_next;
			exc_reg <= exc_next;
			code_reg <= code_next;
			fc_reg <= fc_next;
			bc_reg <= bc_next;
			qty_reg <= qty_next;
			start_reg <= start_next;
		end
	end

	assign tx = '{valid: tx_valid_reg, last: tx_last_reg, data: tx_data_reg};
	assign output_bit_area = bits_reg;
	assign memory_word_area = mem_reg;

	// ==========================================================
	// Checks
	default clocking cb @(posedge clk); endclocking
	default disable iff (!resetn);

	sequence s_crc_lo;
		tx_valid_reg && tx_ready && idx_reg == body_len_reg;
	endsequence
	sequence s_crc_hi;
		tx_last_reg && tx_data_reg == $past(crc_tx_reg[15:8]);
	endsequence

	chk_exc_func: assert property (tx_valid_reg && idx_reg == 6'h01 && exc_reg |-> tx_data_reg == (fc_reg | 8'h80))
		else $error("exception reply lacks flagged function code");
	chk_exc_len: assert property (tx_last_reg && exc_reg |-> idx_reg == 6'h04)
		else $error("exception reply is not five bytes");
	chk_read_count: assert property (tx_valid_reg && idx_reg == 6'h02 && !exc_reg && mbrbs_pkg::is_read(fc_reg) |-> tx_data_reg == 8'((qty_reg + 16'h0007) >> 3))
		else $error("byte count not rounded up");
	chk_read_len: assert property (tx_last_reg && !exc_reg && mbrbs_pkg::is_read(fc_reg) |-> idx_reg == 6'(bc_reg + 8'h04))
		else $error("bit read reply length wrong");
	chk_pad_zero: assert property (tx_valid_reg && !exc_reg && mbrbs_pkg::is_read(fc_reg) && idx_reg == 6'(bc_reg + 8'h02) && qty_reg[2:0] != 3'h0 |-> (tx_data_reg >> qty_reg[2:0]) == 8'h00)
		else $error("unused bits of last byte not zero");
	chk_echo_len: assert property (tx_last_reg && !exc_reg && !mbrbs_pkg::is_read(fc_reg) |-> idx_reg == 6'h07)
		else $error("write reply is not eight bytes");
	chk_crc_order: assert property (s_crc_lo |=> s_crc_hi)
		else $error("crc high byte not sent after low byte");
	chk_bit_set: assert property (state_reg == mbrbs_pkg::ST_CHECK && !exc_next && req_fc == mbrbs_pkg::FC_WRITE_BIT |=> bits_reg[$past(start_next)] == $past(req_qty[15]))
		else $error("single bit write did not land");
	chk_word_map: assert property (state_reg == mbrbs_pkg::ST_CHECK && !exc_next && req_fc == mbrbs_pkg::FC_WRITE_WORDS && req_addr == 16'h0000 |=> mem_reg[0] == $past(first_word))
		else $error("word zero not written from start");
	chk_crc_drop: assert property (state_reg == mbrbs_pkg::ST_IDLE && rx_frame_end && crc_rx_reg != 16'h0000 |=> (state_reg == mbrbs_pkg::ST_IDLE && !tx_valid_reg) [*2])
		else $error("frame with bad crc was answered");
endmodule

//--- mbrbs_master.sv
`timescale 1ns/1ps
module mbrbs_master
(
	// Clock
	input wire logic clk,
	// Request bytes towards the slave
	output mbrbs_pkg::mbrbs_rx_s rx,
	output logic rx_frame_end,
	// Reply bytes from the slave
	input wire mbrbs_pkg::mbrbs_tx_s tx,
	output logic tx_ready
);
	// ==========================================================
	// Master state
	logic [7:0] rsp[$];
	logic stall;

	initial
	begin
		rx = '0;
		rx_frame_end = 1'b0;
		tx_ready = 1'b1;
		stall = 1'b0;
	end

	// ==========================================================
	// Reflected CRC-16, written apart from the slave's own
	function automatic logic [15:0] crc16(input logic [7:0] b[$]);
		logic [15:0] c;
		c = 16'hFFFF;
		foreach (b[i])
		begin
			c = c ^ {8'h00, b[i]};
			for (int k = 0; k < 8; k++)
				c = c[0] ? ((c >> 1) ^ 16'hA001) : (c >> 1);
		end
		return c;
	endfunction

	// ==========================================================
	// One request frame, then collect the reply
	// Body fields come from the caller high byte first
	task automatic xfer(input logic [7:0] b[$], input logic bad);
		logic [15:0] c;
		int w;
		c = crc16(b);
		if (bad)
			c = c ^ 16'h0001;
		b.push_back(c[7:0]);
		b.push_back(c[15:8]);
		rsp.delete();
		foreach (b[i])
		begin
			@(negedge clk);
			rx.valid <= 1'b1;
			rx.data <= b[i];
		end
		@(negedge clk);
		rx.valid <= 1'b0;
		// Released data line shows the inverse, never a stale copy
		rx.data <= ~b[b.size()-1];
		rx_frame_end <= 1'b1;
		@(negedge clk);
		rx_frame_end <= 1'b0;
		for (w = 0; w < 60; w++)
		begin
			@(posedge clk);
			if (tx.valid === 1'b1 && tx_ready)
			begin
				rsp.push_back(tx.data);
				if (tx.last === 1'b1)
					break;
			end
			@(negedge clk);
			// Stalling sink alternates ready to test holding of the byte
			tx_ready <= !stall || !tx_ready;
		end
		@(negedge clk);
		tx_ready <= 1'b1;
	endtask
endmodule

//--- mbrbs_slave_tb.sv
`timescale 1ns/1ps
module mbrbs_slave_tb;
	// ==========================================================
	// Signals
	logic clk;
	logic resetn;
	logic [7:0] slave_id;
	mbrbs_pkg::mbrbs_rx_s rx;
	logic rx_frame_end;
	mbrbs_pkg::mbrbs_tx_s tx;
	logic tx_ready;
	logic [mbrbs_pkg::OUT_BITS-1:0] output_bit_area;
	logic [mbrbs_pkg::MEM_WORDS-1:0][15:0] memory_word_area;
	int err_count;
	int checked;

	mbrbs_slave uut
	(
		.clk(clk),
		.resetn(resetn),
		.slave_id(slave_id),
		.rx(rx),
		.rx_frame_end(rx_frame_end),
		.tx(tx),
		.tx_ready(tx_ready),
		.output_bit_area(output_bit_area),
		.memory_word_area(memory_word_area)
	);

	mbrbs_master master
	(
		.clk(clk),
		.rx(rx),
		.rx_frame_end(rx_frame_end),
		.tx(tx),
		.tx_ready(tx_ready)
	);

	initial
	begin
		clk = 1'b0;
		forever #2.5 clk = ~clk;
	end

	// ==========================================================
	// Shared checks
	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp)
		begin
			err_count++;
			$display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
		end
	endtask

	task automatic expect_rsp(input logic [7:0] e[$]);
		logic [15:0] c;
		c = master.crc16(e);
		e.push_back(c[7:0]);
		e.push_back(c[15:8]);
		check(16'(master.rsp.size()), 16'(e.size()));
		foreach (e[i])
			if (i < master.rsp.size())
				check({8'h00, master.rsp[i]}, {8'h00, e[i]});
	endtask

	task automatic wr_bit(input logic [15:0] a, input logic [15:0] v);
		master.xfer('{8'h01, 8'h05, a[15:8], a[7:0], v[15:8], v[7:0]}, 1'b0);
		expect_rsp('{8'h01, 8'h05, a[15:8], a[7:0], v[15:8], v[7:0]});
	endtask

	// ==========================================================
	// Scenarios
	task automatic t_write_bit();
		wr_bit(16'hA000, 16'hFF00);
		check({15'h0000, output_bit_area[0]}, 16'h0001);
		wr_bit(16'hA3FF, 16'hFF00);
		check({15'h0000, output_bit_area[1023]}, 16'h0001);
		wr_bit(16'hA000, 16'h0000);
		check({15'h0000, output_bit_area[0]}, 16'h0000);
		$display("test write_bit done");
	endtask

	task automatic t_read();
		logic [7:0] fc[2];
		fc = '{8'h01, 8'h02};
		wr_bit(16'hA010, 16'hFF00);
		wr_bit(16'hA017, 16'hFF00);
		wr_bit(16'hA018, 16'hFF00);
		wr_bit(16'hA01C, 16'hFF00);
		wr_bit(16'hA01D, 16'hFF00);
		check({15'h0000, output_bit_area[16]}, 16'h0001);
		master.stall = 1'b1;
		foreach (fc[i])
		begin
			master.xfer('{8'h01, fc[i], 8'hA0, 8'h10, 8'h00, 8'h0D}, 1'b0);
			expect_rsp('{8'h01, fc[i], 8'h02, 8'h81, 8'h11});
		end
		master.xfer('{8'h01, 8'h01, 8'hA0, 8'h10, 8'h00, 8'h08}, 1'b0);
		expect_rsp('{8'h01, 8'h01, 8'h01, 8'h81});
		master.xfer('{8'h01, 8'h02, 8'hA0, 8'h10, 8'h00, 8'h10}, 1'b0);
		expect_rsp('{8'h01, 8'h02, 8'h02, 8'h81, 8'h31});
		master.stall = 1'b0;
		$display("test read_bits done");
	endtask

	task automatic t_words();
		master.xfer('{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02, 8'h04,
			8'h01, 8'h00, 8'h02, 8'h00}, 1'b0);
		expect_rsp('{8'h01, 8'h10, 8'h00, 8'h00, 8'h00, 8'h02});
		check(memory_word_area[0], 16'h0100);
		check(memory_word_area[1], 16'h0200);
		$display("test write_words done");
	endtask

	task automatic t_except();
		master.xfer('{8'h01, 8'h03, 8'h00, 8'h00, 8'h00, 8'h01}, 1'b0);
		expect_rsp('{8'h01, 8'h83, 8'h01});
		master.xfer('{8'h01, 8'h01, 8'hA4, 8'h00, 8'h00, 8'h01}, 1'b0);
		expect_rsp('{8'h01, 8'h81, 8'h02});
		master.xfer('{8'h01, 8'h02, 8'hA0, 8'h00, 8'h00, 8'h00}, 1'b0);
		expect_rsp('{8'h01, 8'h82, 8'h03});
		// Target bit is set, so a wrongly applied bad value would clear it
		master.xfer('{8'h01, 8'h05, 8'hA0, 8'h10, 8'h12, 8'h34}, 1'b0);
		expect_rsp('{8'h01, 8'h85, 8'h03});
		check({15'h0000, output_bit_area[16]}, 16'h0001);
		master.xfer('{8'h01, 8'h10, 8'h00, 8'h0F, 8'h00, 8'h02, 8'h04,
			8'hAA, 8'hBB, 8'hCC, 8'hDD}, 1'b0);
		expect_rsp('{8'h01, 8'h90, 8'h02});
		check(memory_word_area[15], 16'h0000);
		$display("test exceptions done");
	endtask

	task automatic t_discard();
		master.xfer('{8'h01, 8'h05, 8'hA0, 8'h01, 8'hFF, 8'h00}, 1'b1);
		check(16'(master.rsp.size()), 16'h0000);
		check({15'h0000, output_bit_area[1]}, 16'h0000);
		master.xfer('{8'h02, 8'h05, 8'hA0, 8'h01, 8'hFF, 8'h00}, 1'b0);
		check(16'(master.rsp.size()), 16'h0000);
		wr_bit(16'hA001, 16'hFF00);
		check({15'h0000, output_bit_area[1]}, 16'h0001);
		$display("test discard done");
	endtask

	// ==========================================================
	// Verdict and run control
	task automatic print_verdict();
		$display("checks %0d mismatches %0d", checked, err_count);
		if (err_count == 0 && checked > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask

	initial
	begin
		#200000;
		err_count++;
		print_verdict();
	end

	initial
	begin
		err_count = 0;
		checked = 0;
		resetn = 1'b0;
		slave_id = 8'h01;
		repeat (12) @(negedge clk);
		resetn <= 1'b1;
		repeat (2) @(negedge clk);
		check(16'(output_bit_area[15:0]), 16'h0000);
		t_write_bit();
		t_read();
		t_words();
		t_except();
		t_discard();
		print_verdict();
	end
endmodule
